// ### kbe_pkg.sv
// Shared constants for the keyboard buffer cursor entry block
`default_nettype none
package kbe_pkg;
    // Buffer word layout: data byte, cursor flag, parity
    localparam int unsigned   WORD_W     = 10;
    localparam int unsigned   CODE_W     = 8;
    localparam int unsigned   CURSOR_BIT = 8;
    localparam int unsigned   PARITY_BIT = 9;
    localparam logic [7:0]    NULL_CODE  = 8'h00;

    // Register offsets on the plain register port
    localparam int unsigned   REG_AW       = 8;
    localparam logic [7:0]    REG_CTRL     = 8'h00;
    localparam logic [7:0]    REG_STATUS   = 8'h04;
    localparam logic [7:0]    REG_CURSOR   = 8'h08;
    localparam logic [7:0]    REG_HOSTADDR = 8'h0c;
    localparam logic [7:0]    REG_HOSTDATA = 8'h10;

    // Control and status field positions
    localparam int unsigned   CTRL_REGEN   = 0;
    localparam int unsigned   CTRL_UNPROT  = 1;
    localparam int unsigned   STAT_KEYPEND = 0;
    localparam int unsigned   STAT_FWDPEND = 1;
    localparam int unsigned   STAT_BUSY    = 2;
    localparam logic [1:0]    CTRL_RESET   = 2'h0;

    // Key buffer depth
    localparam int unsigned   KEY_DEPTH    = 2;
endpackage : kbe_pkg
`default_nettype wire

// ### kbe_buf_if.sv
// Buffer storage port between the sequencer and the storage array
`default_nettype none
interface kbe_buf_if #(
    parameter int unsigned ADDR_W = 12
);
    logic                       rd;
    logic                       wr;
    logic [ADDR_W-1:0]          addr;
    logic [kbe_pkg::WORD_W-1:0] wdata;
    logic [kbe_pkg::WORD_W-1:0] rdata;

    modport ctrl (output rd, output wr, output addr, output wdata, input rdata);
    modport mem  (input rd, input wr, input addr, input wdata, output rdata);
endinterface : kbe_buf_if
`default_nettype wire

// ### kbe_buf_mem.sv
// Refresh buffer storage array with registered read data
`default_nettype none
module kbe_buf_mem #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic clk_i,
    kbe_buf_if.mem    port
);
    localparam int unsigned DEPTH = 1 << ADDR_W;

    logic [kbe_pkg::WORD_W-1:0] store [DEPTH];

    // Write port; contents are not reset, software loads them
    always_ff @(posedge clk_i) begin
        if (port.wr) begin
            store[port.addr] <= port.wdata;
        end
    end

    // Read data stands in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (port.rd) begin
            port.rdata <= store[port.addr];
        end
    end
endmodule : kbe_buf_mem
`default_nettype wire

// ### kbe_entry.sv
// Regeneration sequencer with cursor-flag keyboard entry
`default_nettype none
// Summary of operation
// - Entry only while regenerating, in unprotected character mode, on a cursor-flagged word.
// - Cursor word may hold a character (cursor shown) or null (hidden, entry works).
// - Keyboard offers key code with a pending indication to the sequencer.
// - Every regenerated word is tested for cursor flag and pending key.
// - Normal cycle: clear, transfer counter, read, step, write, examine.
// - Cursor hit with pending key holds the counter until the adjust write steps it back one.
// - Next word: read, set cursor flag, invert parity, write, counter minus one.
// - Old cursor word: clear, read, step, load key, clear flag, invert parity, write, show.
// - Cursor word without pending key shows the cursor and stepping continues.
// - Blank or symbol at the cursor is overwritten the same way.
// - Null key code is entered like any character, zeroing data bits 0 to 7.
// - Null word draws nothing and gives no character spacing.
// - Cursor-forward key moves the flag one word, onto null words too.
module kbe_entry #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [kbe_pkg::REG_AW-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [31:0]                reg_rdata_o,
    input  wire logic [kbe_pkg::CODE_W-1:0] key_code_i,
    input  wire logic                       key_valid_i,
    output logic                            key_ready_o,
    input  wire logic                       fwd_key_i,
    output logic                            char_valid_o,
    output logic      [kbe_pkg::CODE_W-1:0] char_code_o,
    output logic                            char_cursor_o,
    input  wire logic                       char_ready_i
);
    // Elaboration-time check: counter and storage serve 2 to 16 address bits only
    if (ADDR_W < 2 || ADDR_W > 16) begin : g_bad_addr_w
        $error("kbe_entry: ADDR_W must lie between 2 and 16");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_XFR, S_RD, S_STEP, S_WR, S_EXAM, S_EMIT,
        S_AXFR, S_ARD, S_AMOD, S_AWR, S_EXFR, S_ERD, S_EMOD, S_EWR
    } kbe_state_e;

    kbe_state_e                 state;
    logic [ADDR_W-1:0]          buffer_address_counter;
    logic [ADDR_W-1:0]          bar;
    logic [kbe_pkg::WORD_W-1:0] breg;
    logic [1:0]                 ctrl;
    logic [ADDR_W-1:0]          host_addr;
    logic [ADDR_W-1:0]          cursor_addr;
    logic                       fwd_pend;
    logic                       op_fwd;
    logic [kbe_pkg::CODE_W-1:0] key_q [kbe_pkg::KEY_DEPTH];
    logic [1:0]                 key_cnt;
    logic [1:0]                 next_key_cnt;
    logic                       key_push;
    logic                       key_pop;
    logic                       key_pend;
    logic                       hit;
    logic                       host_wr;

    kbe_buf_if #(.ADDR_W(ADDR_W)) buf_port ();

    kbe_buf_mem #(.ADDR_W(ADDR_W)) u_mem (
        .clk_i (clk_i),
        .port  (buf_port)
    );

    // Word helpers shared by the modify steps
    function automatic logic w_cursor(input logic [kbe_pkg::WORD_W-1:0] w);
        return w[kbe_pkg::CURSOR_BIT];
    endfunction

    function automatic logic [kbe_pkg::CODE_W-1:0] w_code(
        input logic [kbe_pkg::WORD_W-1:0] w);
        return w[kbe_pkg::CODE_W-1:0];
    endfunction

    // Pending key and forward indications seen by the sequencer
    assign key_pend = (key_cnt != 2'h0);
    assign hit      = ctrl[kbe_pkg::CTRL_UNPROT] && w_cursor(breg)
                      && (key_pend || fwd_pend);
    assign key_push = key_valid_i && key_ready_o;
    assign key_pop  = (state == S_EWR) && !op_fwd;
    assign host_wr  = reg_wr_i && (reg_addr_i == kbe_pkg::REG_HOSTDATA)
                      && (state == S_IDLE) && !ctrl[kbe_pkg::CTRL_REGEN];

    // Storage port steering; host loads words only while regeneration is off
    always_comb begin
        buf_port.rd    = (state == S_RD) || (state == S_ARD) || (state == S_ERD);
        buf_port.wr    = (state == S_WR) || (state == S_AWR) || (state == S_EWR) || host_wr;
        buf_port.addr  = (state == S_IDLE) ? host_addr : bar;
        buf_port.wdata = (state == S_IDLE) ? reg_wdata_i[kbe_pkg::WORD_W-1:0] : breg;
    end

    // Two-entry key buffer count; a full buffer stalls the keyboard
    always_comb begin
        next_key_cnt = key_cnt;
        if (key_push && !key_pop) begin
            next_key_cnt = key_cnt + 2'h1;
        end else if (key_pop && !key_push) begin
            next_key_cnt = key_cnt - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            key_cnt     <= 2'h0;
            key_ready_o <= 1'b0;
        end else begin
            key_cnt     <= next_key_cnt;
            key_ready_o <= (next_key_cnt != 2'(kbe_pkg::KEY_DEPTH));
        end
    end

    // Key entries: head in slot 0, shifted on pop
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            key_q[0] <= kbe_pkg::NULL_CODE;
            key_q[1] <= kbe_pkg::NULL_CODE;
        end else begin
            if (key_pop) begin
                key_q[0] <= key_q[1];
            end
            if (key_push) begin
                if (key_pop ? (key_cnt == 2'h1) : (key_cnt == 2'h0)) begin
                    key_q[0] <= key_code_i;
                end else begin
                    key_q[1] <= key_code_i;
                end
            end
        end
    end

    // Forward key request; a new press wins over the clear
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            fwd_pend <= 1'b0;
        end else if (fwd_key_i) begin
            fwd_pend <= 1'b1;
        end else if ((state == S_EWR) && op_fwd) begin
            fwd_pend <= 1'b0;
        end
    end

    // Sequencer state
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE:  state <= ctrl[kbe_pkg::CTRL_REGEN] ? S_XFR : S_IDLE;
                S_XFR:   state <= S_RD;
                S_RD:    state <= S_STEP;
                S_STEP:  state <= S_WR;
                S_WR:    state <= S_EXAM;
                S_EXAM: begin
                    if (hit) begin
                        state <= S_AXFR;
                    end else if (w_code(breg) != kbe_pkg::NULL_CODE) begin
                        state <= S_EMIT;
                    end else begin
                        state <= ctrl[kbe_pkg::CTRL_REGEN] ? S_XFR : S_IDLE;
                    end
                end
                S_EMIT: begin
                    if (char_ready_i) begin
                        state <= ctrl[kbe_pkg::CTRL_REGEN] ? S_XFR : S_IDLE;
                    end
                end
                S_AXFR:  state <= S_ARD;
                S_ARD:   state <= S_AMOD;
                S_AMOD:  state <= S_AWR;
                S_AWR:   state <= S_EXFR;
                S_EXFR:  state <= S_ERD;
                S_ERD:   state <= S_EMOD;
                S_EMOD:  state <= S_EWR;
                S_EWR:   state <= S_EXAM;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Latch whether this adjustment serves a key or a cursor-forward press
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            op_fwd <= 1'b0;
        end else if (state == S_EXAM && hit) begin
            op_fwd <= !key_pend;
        end
    end

    // Address counter: no step from examine until the adjust write
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            buffer_address_counter <= '0;
        end else begin
            case (state)
                S_STEP:  buffer_address_counter <= buffer_address_counter + 1'b1;
                S_AWR:   buffer_address_counter <= buffer_address_counter - 1'b1;
                S_EMOD:  buffer_address_counter <= buffer_address_counter + 1'b1;
                default: buffer_address_counter <= buffer_address_counter;
            endcase
        end
    end

    // Address register follows the counter on each transfer step
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bar <= '0;
        end else if (state == S_XFR || state == S_AXFR || state == S_EXFR) begin
            bar <= buffer_address_counter;
        end
    end

    // Data register: clear, load, and the two cursor-move edits
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            breg <= '0;
        end else begin
            case (state)
                S_XFR, S_AXFR, S_EXFR: breg <= '0;
                S_STEP: breg <= buf_port.rdata;
                S_AMOD: begin
                    breg                       <= buf_port.rdata;
                    breg[kbe_pkg::CURSOR_BIT]  <= 1'b1;
                    breg[kbe_pkg::PARITY_BIT]  <= ~buf_port.rdata[kbe_pkg::PARITY_BIT];
                end
                S_EMOD: begin
                    // Old code overwritten by the key, blank or symbol alike; a forward move keeps it
                    breg[kbe_pkg::CODE_W-1:0] <= op_fwd ? w_code(buf_port.rdata)
                                                        : key_q[0];
                    breg[kbe_pkg::CURSOR_BIT] <= 1'b0;
                    breg[kbe_pkg::PARITY_BIT] <= ~buf_port.rdata[kbe_pkg::PARITY_BIT];
                end
                default: breg <= breg;
            endcase
        end
    end

    // Character generator output; null words never reach it
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            char_valid_o  <= 1'b0;
            char_code_o   <= kbe_pkg::NULL_CODE;
            char_cursor_o <= 1'b0;
        end else if (state == S_EXAM && !hit && w_code(breg) != kbe_pkg::NULL_CODE) begin
            char_valid_o  <= 1'b1;
            char_code_o   <= w_code(breg);
            char_cursor_o <= w_cursor(breg);
        end else if (char_ready_i) begin
            char_valid_o  <= 1'b0;
        end
    end

    // Last address where the cursor flag was seen
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cursor_addr <= '0;
        end else if (state == S_EXAM && w_cursor(breg)) begin
            cursor_addr <= bar;
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl      <= kbe_pkg::CTRL_RESET;
            host_addr <= '0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == kbe_pkg::REG_CTRL) begin
                ctrl <= reg_wdata_i[1:0];
            end
            if (reg_addr_i == kbe_pkg::REG_HOSTADDR) begin
                host_addr <= reg_wdata_i[ADDR_W-1:0];
            end else if (host_wr) begin
                host_addr <= host_addr + 1'b1;   // Auto-advance eases bulk loads
            end
        end
    end

    // Register reads, one cycle later; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    kbe_pkg::REG_CTRL:     reg_rdata_o <= {30'h0, ctrl};
                    kbe_pkg::REG_STATUS: begin
                        reg_rdata_o[kbe_pkg::STAT_KEYPEND] <= key_pend;
                        reg_rdata_o[kbe_pkg::STAT_FWDPEND] <= fwd_pend;
                        reg_rdata_o[kbe_pkg::STAT_BUSY]    <= (state != S_IDLE);
                    end
                    kbe_pkg::REG_CURSOR:   reg_rdata_o <= 32'(cursor_addr);
                    kbe_pkg::REG_HOSTADDR: reg_rdata_o <= 32'(host_addr);
                    default:               reg_rdata_o <= '0;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence normal_steps_s;
        state == S_RD ##1 state == S_STEP ##1 state == S_WR ##1 state == S_EXAM;
    endsequence

    sequence adjust_steps_s;
        state == S_AXFR ##1 state == S_ARD ##1 state == S_AMOD ##1 state == S_AWR;
    endsequence

    sequence entry_steps_s;
        state == S_EXFR ##1 state == S_ERD ##1 state == S_EMOD ##1 state == S_EWR;
    endsequence

    entry_gate_a: assert property ((state == S_EXAM && !ctrl[kbe_pkg::CTRL_UNPROT])
        |=> state != S_AXFR) else $error("entry outside unprotected mode");
    cycle_order_a: assert property (state == S_XFR |=> normal_steps_s)
        else $error("normal buffer cycle out of order");
    cursor_test_a: assert property ((state == S_EXAM && hit)
        |=> adjust_steps_s ##1 entry_steps_s ##1 state == S_EXAM)
        else $error("cursor move sequence broken");
    step_hold_a: assert property ((state == S_EXAM && hit)
        |=> $stable(buffer_address_counter) [*3]) else $error("counter stepped early");
    adjust_write_a: assert property (state == S_AWR |-> buf_port.wr
        && w_cursor(buf_port.wdata) ##1 buffer_address_counter == bar - 1'b1)
        else $error("adjust write wrong");
    entry_write_a: assert property (state == S_EWR |-> buf_port.wr
        && !w_cursor(buf_port.wdata) && buffer_address_counter == bar + 1'b1)
        else $error("entry write wrong");
    key_code_a: assert property ((state == S_EMOD && !op_fwd)
        |=> w_code(breg) == $past(key_q[0])) else $error("key code not stored");
    cursor_show_a: assert property ((state == S_EXAM && w_cursor(breg) && !hit
        && w_code(breg) != kbe_pkg::NULL_CODE) |=> char_valid_o && char_cursor_o)
        else $error("cursor not shown");
    null_skip_a: assert property ((state == S_EXAM && w_code(breg) == kbe_pkg::NULL_CODE)
        |=> !$rose(char_valid_o)) else $error("null word drawn");
    single_pop_a: assert property (key_pop |=> !key_pop [*4])
        else $error("key entered twice");
endmodule : kbe_entry
`default_nettype wire

// ### kbe_far_model.sv
// Keyboard source and character generator sink facing the entry block
`default_nettype none
module kbe_far_model (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    output logic [7:0]      key_code_o,
    output logic            key_valid_o,
    input  wire logic       key_ready_i,
    input  wire logic       char_valid_i,
    input  wire logic [7:0] char_code_i,
    input  wire logic       char_cursor_i,
    output logic            char_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] key_q[$];
    logic [8:0] seen_q[$];

    // Bench queues keystrokes here
    task automatic push_key(input logic [7:0] c);
        key_q.push_back(c);
    endtask

    // Quiet lines until the first reset edge
    initial begin
        key_code_o   = 8'h00;
        key_valid_o  = 1'b0;
        char_ready_o = 1'b0;
    end

    // Offer held until taken; idle code toggles so a stale code cannot pass
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            key_valid_o <= 1'b0;
            key_code_o  <= 8'h00;
        end else begin
            if (key_valid_o && key_ready_i) begin
                void'(key_q.pop_front());
            end
            key_valid_o <= (key_q.size() > 0);
            key_code_o  <= (key_q.size() > 0) ? key_q[0] : ~key_code_o;
        end
    end

    // Generator sink stalls at random; every accepted character is logged
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            char_ready_o <= 1'b0;
        end else begin
            if (char_valid_i && char_ready_o) begin
                seen_q.push_back({char_cursor_i, char_code_i});
            end
            char_ready_o <= ($urandom % 2 == 0);
        end
    end
endmodule // kbe_far_model
`default_nettype wire

// ### test_keyboard_buffer_cursor_entry.sv
// Self-checking bench for the cursor-flag keyboard entry block
`default_nettype none
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); \
    end \
end
module test_keyboard_buffer_cursor_entry;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned AW = 4;
    localparam int unsigned NW = 16;
    logic        clk_i       = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        fwd_key_i   = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [7:0]  key_code;
    logic        key_valid;
    logic        key_ready;
    logic        char_valid;
    logic [7:0]  char_code;
    logic        char_cursor;
    logic        char_ready;
    int          fails       = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          cur;
    logic [7:0]  mem [NW];
    logic [31:0] rd;
    logic [7:0]  k0;
    logic [7:0]  k1;

    kbe_entry #(.ADDR_W(AW)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .key_code_i(key_code), .key_valid_i(key_valid),
        .key_ready_o(key_ready), .fwd_key_i(fwd_key_i), .char_valid_o(char_valid),
        .char_code_o(char_code), .char_cursor_o(char_cursor), .char_ready_i(char_ready));

    kbe_far_model far (.clk_i(clk_i), .rst_b_i(rst_b_i), .key_code_o(key_code),
        .key_valid_o(key_valid), .key_ready_i(key_ready), .char_valid_i(char_valid),
        .char_code_i(char_code), .char_cursor_i(char_cursor), .char_ready_o(char_ready));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic end_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, fails);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        rd = reg_rdata_o;
    endtask

    // Poll a status bit until it drops and the keyboard has nothing left to offer
    task automatic wait_clear(input int b);
        for (int i = 0; i < 400; i++) begin
            rd_reg(kbe_pkg::REG_STATUS);
            if (rd[b] === 1'b0 && far.key_q.size() == 0) begin
                break;
            end
        end
    endtask

    // One pass seen from the cursor word must match the model, nulls left out
    task automatic check_stream();
        int i0;
        int j;
        i0 = -1;
        j  = 0;
        far.seen_q.delete();
        repeat (700) @(posedge clk_i);
        foreach (far.seen_q[i]) begin
            if (i0 < 0 && far.seen_q[i][8] === 1'b1) begin
                i0 = i;
            end
        end
        `CHK("cursor shown", 1'b1, i0 >= 0)
        for (int a = 0; a < NW && i0 >= 0; a++) begin
            if (mem[(cur + a) % NW] != 8'h00) begin
                `CHK("char", {a == 0, mem[(cur + a) % NW]}, far.seen_q[i0 + j])
                j++;
            end
        end
    endtask

    task automatic cursor_is(input int exp);
        repeat (300) @(posedge clk_i);
        rd_reg(kbe_pkg::REG_CURSOR);
        `CHK("cursor addr", 32'(exp), rd)
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'hf1e00479));
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd_reg(kbe_pkg::REG_CTRL);
        `CHK("ctrl reset", 32'h0, rd)
        rd_reg(8'h14);
        `CHK("unmapped", 32'h0, rd)
        rd_reg(kbe_pkg::REG_STATUS);
        `CHK("status idle", 32'h0, rd)
        // Random symbols, nulls at 2 and 6, cursor on word 1
        wr_reg(kbe_pkg::REG_HOSTADDR, 32'h0);
        for (int a = 0; a < NW; a++) begin
            mem[a] = (a inside {2, 6}) ? 8'h00 : 8'h01 + 8'($urandom % 63);
            wr_reg(kbe_pkg::REG_HOSTDATA, {22'h0, 1'b0, a == 1, mem[a]});
        end
        cur = 1;
        end_test("registers");
        // Idle sequencer: the two-entry key buffer fills and refuses the third
        k0 = 8'h01 + 8'($urandom % 63);
        k1 = 8'h01 + 8'($urandom % 63);
        far.push_key(k0);
        far.push_key(k1);
        far.push_key(8'h00);
        repeat (20) @(posedge clk_i);
        #1;
        `CHK("key ready full", 1'b0, key_ready)
        `CHK("keys left", 1, far.key_q.size())
        rd_reg(kbe_pkg::REG_STATUS);
        `CHK("key pending", 1'b1, rd[0])
        end_test("fill");
        // Protected mode: cursor shown, nothing entered
        wr_reg(kbe_pkg::REG_CTRL, 32'h1);
        cursor_is(1);
        rd_reg(kbe_pkg::REG_STATUS);
        `CHK("still pending", 1'b1, rd[0])
        check_stream();
        end_test("protected");
        // Unprotected: keys land on words 1..3; null word 2 takes a symbol, the null key zeroes word 3
        wr_reg(kbe_pkg::REG_CTRL, 32'h3);
        wait_clear(kbe_pkg::STAT_KEYPEND);
        mem[1] = k0;
        mem[2] = k1;
        mem[3] = 8'h00;
        cur = 4;
        // Host write while regenerating must be ignored
        wr_reg(kbe_pkg::REG_HOSTADDR, 32'h9);
        wr_reg(kbe_pkg::REG_HOSTDATA, 32'h0ff);
        cursor_is(cur);
        check_stream();
        end_test("entry");
        // Forward key steps the flag, across the null word 6 as well
        for (int n = 0; n < 3; n++) begin
            @(posedge clk_i);
            fwd_key_i <= 1'b1;
            @(posedge clk_i);
            fwd_key_i <= 1'b0;
            wait_clear(kbe_pkg::STAT_FWDPEND);
            cur++;
            cursor_is(cur);
        end
        check_stream();
        end_test("forward");
        give_verdict();
    end
endmodule // test_keyboard_buffer_cursor_entry
`default_nettype wire
